//--- nsr_params.svh
// Constant offsets, field positions, reset values and opcode fields of the instruction core.
`ifndef NSR_PARAMS_SVH
`define NSR_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define NSR_OFF_INSTR 6'h00
`define NSR_OFF_BANK 6'h04
`define NSR_OFF_CFG 6'h08
`define NSR_OFF_INDEX 6'h0c
`define NSR_OFF_STATUS 6'h10
`define NSR_OFF_PC 6'h14
`define NSR_OFF_TOP 6'h18
`define NSR_OFF_STATE 6'h1c
`define NSR_OFF_DADDR 6'h20
`define NSR_OFF_DDATA 6'h24
`define NSR_OFF_EADDR 6'h28

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define NSR_ST_C 0
`define NSR_ST_DC 1
`define NSR_ST_Z 2
`define NSR_ST_OV 3
`define NSR_ST_N 4
`define NSR_CFG_EXT 0
`define NSR_STATUS_RST 5'h00
`define NSR_BANK_RST 4'h0
`define NSR_INDEX_RST 12'h000
`define NSR_PC_RST 21'h000000

// ----------------------------------------------------------------------------
// Opcode fields and timing
// ----------------------------------------------------------------------------
`define NSR_NEG_TOP 7'h36
`define NSR_RELATIVE_SUBROUTINE_CALL_TOP 5'h1b
`define NSR_DISCARD_WORD 16'h0006
`define NSR_SAVE_WORD 16'h0005
`define NSR_IDLE_WORD 16'h0000
`define NSR_IDLE_TOP 4'hf
`define NSR_ACCESS_LIM 8'h5f
`define NSR_SFR_BANK 4'hf
`define NSR_PC_STEP 21'h000002
`define NSR_Q_LAST 2'h3
`define NSR_STK_DEPTH 31

`endif

//--- nsr_pkg.sv
// Types used by the instruction core: opcode classes and sequencer states.
package nsr_pkg;

    typedef enum logic [2:0] {
        NSR_OP_IDLE,
        NSR_OP_NEG,
        NSR_OP_DISCARD,
        NSR_OP_SAVE,
        NSR_OP_RELATIVE_SUBROUTINE_CALL
    } nsr_op_e;

    typedef enum logic [1:0] {
        NSR_ST_IDLE,
        NSR_ST_EXEC,
        NSR_ST_SECOND
    } nsr_state_e;

endpackage : nsr_pkg

//--- nsr_stk_if.sv
// Connection between the instruction core and the return stack.
`timescale 1ns/1ps
`default_nettype none

interface nsr_stk_if #(
    parameter int AW = 21,
    parameter int PW = 5
);
    logic push;
    logic pop;
    logic [AW-1:0] push_data;
    logic [AW-1:0] top;
    logic [PW-1:0] depth;
    logic full;
    logic empty;
    logic overflow;
    logic underflow;

    modport core (
        output push, pop, push_data,
        input top, depth, full, empty, overflow, underflow
    );
    modport stack (
        input push, pop, push_data,
        output top, depth, full, empty, overflow, underflow
    );
endinterface : nsr_stk_if

`default_nettype wire

//--- nsr_rstack.sv
// Return stack held in flip-flops, indexed by a depth pointer.
`include "nsr_params.svh"
`timescale 1ns/1ps
`default_nettype none

module nsr_rstack #(
    parameter int DEPTH = `NSR_STK_DEPTH,
    parameter int AW = 21,
    parameter int PW = 5
) (
    input wire logic i_mclk,  // Core clock.
    input wire logic i_rst,   // Synchronous reset, active high.
    input wire logic i_ce,    // Clock enable, freezes the stack when low.
    nsr_stk_if.stack stk      // Push and pop port.
);
    logic [AW-1:0] mem_q [DEPTH];
    logic [PW-1:0] sp_q;
    logic ovf_q;
    logic unf_q;

    assign stk.full = (sp_q == PW'(DEPTH));
    assign stk.empty = (sp_q == '0);
    assign stk.depth = sp_q;
    assign stk.top = stk.empty ? '0 : mem_q[sp_q - PW'(1)];
    assign stk.overflow = ovf_q;
    assign stk.underflow = unf_q;

    // ------------------------------------------------------------------------
    // Pointer and storage
    // ------------------------------------------------------------------------
    // A push on a full stack or a pop on an empty one leaves the stack alone
    // and raises a sticky error flag instead.
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            sp_q <= '0;
            ovf_q <= 1'b0;
            unf_q <= 1'b0;
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
        end else if (i_ce) begin
            if (stk.push) begin
                if (stk.full) begin
                    ovf_q <= 1'b1;
                end else begin
                    mem_q[sp_q] <= stk.push_data;
                    sp_q <= sp_q + PW'(1);
                end
            end else if (stk.pop) begin
                if (stk.empty) begin
                    unf_q <= 1'b1;
                end else begin
                    sp_q <= sp_q - PW'(1);
                end
            end
        end
    end

endmodule : nsr_rstack

`default_nettype wire

//--- nsr_core.sv
// Instruction core: negate, idle, stack discard, stack save and relative call.
//
// Our own choices: the placing of the registers and the Avalon-MM register port.
`include "nsr_params.svh"
`timescale 1ns/1ps
`default_nettype none

module nsr_core #(
    parameter int DMEM_AW = 12,
    parameter int STK_DEPTH = `NSR_STK_DEPTH
) (
    input wire logic i_mclk,                 // Core clock, 25 MHz.
    input wire logic i_rst,                  // Synchronous reset, active high.
    input wire logic i_ce,                   // Clock enable, freezes all state.
    input wire logic [5:0] i_avs_address,    // Avalon byte address.
    input wire logic i_avs_read,             // Avalon read request.
    input wire logic i_avs_write,            // Avalon write request.
    input wire logic [31:0] i_avs_writedata, // Avalon write data.
    input wire logic [3:0] i_avs_byteenable, // Avalon byte enables.
    output logic [31:0] o_avs_readdata,      // Avalon read data.
    output logic o_avs_waitrequest,          // Avalon wait request.
    output logic o_busy                      // Instruction in progress.
);
    localparam int DMEM_N = 1 << DMEM_AW;
    localparam int PW = $clog2(STK_DEPTH + 1);

    // ------------------------------------------------------------------------
    // Decode functions
    // ------------------------------------------------------------------------
    function automatic nsr_pkg::nsr_op_e op_class(input logic [15:0] w);
        if (w[15:9] == `NSR_NEG_TOP) begin
            return nsr_pkg::NSR_OP_NEG;
        end else if (w[15:11] == `NSR_RELATIVE_SUBROUTINE_CALL_TOP) begin
            return nsr_pkg::NSR_OP_RELATIVE_SUBROUTINE_CALL;
        end else if (w == `NSR_DISCARD_WORD) begin
            return nsr_pkg::NSR_OP_DISCARD;
        end else if (w == `NSR_SAVE_WORD) begin
            return nsr_pkg::NSR_OP_SAVE;
        end
        return nsr_pkg::NSR_OP_IDLE;
    endfunction : op_class

    function automatic logic [11:0] eff_addr(input logic [7:0] f, input logic a,
                                             input logic [3:0] bank, input logic ext,
                                             input logic [11:0] index);
        if (a) begin
            return {bank, f};
        end else if (ext && f <= `NSR_ACCESS_LIM) begin
            return index + {4'h0, f};
        end else if (f <= `NSR_ACCESS_LIM) begin
            return {4'h0, f};
        end
        return {`NSR_SFR_BANK, f};
    endfunction : eff_addr

    function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                               input logic [31:0] wd,
                                               input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = wd[8*i +: 8];
            end
        end
        return r;
    endfunction : lane_merge

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    nsr_pkg::nsr_state_e st_q;
    nsr_pkg::nsr_op_e op_q;
    logic [1:0] phase_q;
    logic [15:0] ir_q;
    logic [20:0] pc_q;
    logic [15:0] cyc_q;
    logic [3:0] bank_q;
    logic ext_q;
    logic [11:0] index_q;
    logic [11:0] daddr_q;
    logic [11:0] eaddr_q;
    logic [4:0] status_q;
    logic [7:0] rd_q;
    logic [7:0] res_q;
    logic [7:0] dmem_q [DMEM_N];
    logic wait_q;
    logic [31:0] rdata_q;
    logic busy_q;
    logic [31:0] rdata_c;
    logic [31:0] wm_c;
    logic [11:0] ea_c;
    logic q4;
    logic bus_wr;
    logic start;

    nsr_stk_if #(.AW(21), .PW(PW)) stk ();

    nsr_rstack #(.DEPTH(STK_DEPTH), .AW(21), .PW(PW)) u_rstack (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .stk(stk)
    );

    assign ea_c = eff_addr(ir_q[7:0], ir_q[8], bank_q, ext_q, index_q);
    assign q4 = (phase_q == `NSR_Q_LAST);
    assign bus_wr = i_avs_write && !wait_q;
    assign start = bus_wr && (i_avs_address == `NSR_OFF_INSTR) && i_avs_byteenable[0];

    // ------------------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------------------
    // Every access waits one cycle; writes also wait while an instruction runs.
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            wait_q <= 1'b1;
            rdata_q <= 32'h0;
        end else if (i_ce) begin
            if (!wait_q) begin
                wait_q <= 1'b1;
            end else if (i_avs_read || (i_avs_write && st_q == nsr_pkg::NSR_ST_IDLE)) begin
                wait_q <= 1'b0;
                rdata_q <= i_avs_read ? rdata_c : 32'h0;
            end
        end
    end

    always_comb begin
        unique case (i_avs_address)
            `NSR_OFF_BANK: rdata_c = {28'h0, bank_q};
            `NSR_OFF_CFG: rdata_c = {31'h0, ext_q};
            `NSR_OFF_INDEX: rdata_c = {20'h0, index_q};
            `NSR_OFF_STATUS: rdata_c = {27'h0, status_q};
            `NSR_OFF_PC: rdata_c = {11'h0, pc_q};
            `NSR_OFF_TOP: rdata_c = {11'h0, stk.top};
            `NSR_OFF_STATE: rdata_c = {cyc_q, 2'h0, stk.underflow, stk.overflow,
                                       3'h0, 8'(stk.depth), busy_q};
            `NSR_OFF_DADDR: rdata_c = {20'h0, daddr_q};
            `NSR_OFF_DDATA: rdata_c = {24'h0, dmem_q[daddr_q[DMEM_AW-1:0]]};
            `NSR_OFF_EADDR: rdata_c = {20'h0, eaddr_q};
            default: rdata_c = 32'h0;
        endcase
    end

    assign o_avs_waitrequest = wait_q;
    assign o_avs_readdata = rdata_q;
    assign o_busy = busy_q;
    // The addressed register's current value with the enabled byte lanes replaced.
    assign wm_c = lane_merge(rdata_c, i_avs_writedata, i_avs_byteenable);

    // ------------------------------------------------------------------------
    // Software configuration
    // ------------------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            bank_q <= `NSR_BANK_RST;
            ext_q <= 1'b0;
            index_q <= `NSR_INDEX_RST;
            daddr_q <= 12'h000;
        end else if (i_ce && bus_wr) begin
            unique case (i_avs_address)
                `NSR_OFF_BANK: bank_q <= wm_c[3:0];
                `NSR_OFF_CFG: ext_q <= wm_c[`NSR_CFG_EXT];
                `NSR_OFF_INDEX: index_q <= wm_c[11:0];
                `NSR_OFF_DADDR: daddr_q <= wm_c[11:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Sequencer and program counter
    // ------------------------------------------------------------------------
    // Each instruction cycle is four clocks, Q1 to Q4.
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            st_q <= nsr_pkg::NSR_ST_IDLE;
            op_q <= nsr_pkg::NSR_OP_IDLE;
            phase_q <= 2'h0;
            ir_q <= 16'h0000;
            pc_q <= `NSR_PC_RST;
            cyc_q <= 16'h0000;
            busy_q <= 1'b0;
            eaddr_q <= 12'h000;
        end else if (i_ce) begin
            unique case (st_q)
                nsr_pkg::NSR_ST_IDLE: begin
                    if (start) begin
                        st_q <= nsr_pkg::NSR_ST_EXEC;
                        ir_q <= i_avs_writedata[15:0];
                        op_q <= op_class(i_avs_writedata[15:0]);
                        phase_q <= 2'h0;
                        busy_q <= 1'b1;
                    end else if (bus_wr && i_avs_address == `NSR_OFF_PC) begin
                        pc_q <= wm_c[20:0];
                    end
                end
                nsr_pkg::NSR_ST_EXEC: begin
                    phase_q <= phase_q + 2'h1;
                    if (op_q == nsr_pkg::NSR_OP_NEG) begin
                        eaddr_q <= ea_c;
                    end
                    if (q4) begin
                        cyc_q <= cyc_q + 16'h1;
                        if (op_q == nsr_pkg::NSR_OP_RELATIVE_SUBROUTINE_CALL) begin
                            pc_q <= pc_q + `NSR_PC_STEP
                                    + {{9{ir_q[10]}}, ir_q[10:0], 1'b0};
                            st_q <= nsr_pkg::NSR_ST_SECOND;
                        end else begin
                            pc_q <= pc_q + `NSR_PC_STEP;
                            st_q <= nsr_pkg::NSR_ST_IDLE;
                            busy_q <= 1'b0;
                        end
                    end
                end
                nsr_pkg::NSR_ST_SECOND: begin
                    phase_q <= phase_q + 2'h1;
                    if (q4) begin
                        cyc_q <= cyc_q + 16'h1;
                        st_q <= nsr_pkg::NSR_ST_IDLE;
                        busy_q <= 1'b0;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Return stack control
    // ------------------------------------------------------------------------
    assign stk.push = i_ce && st_q == nsr_pkg::NSR_ST_EXEC && phase_q == 2'h1
                      && (op_q == nsr_pkg::NSR_OP_SAVE || op_q == nsr_pkg::NSR_OP_RELATIVE_SUBROUTINE_CALL);
    assign stk.pop = i_ce && st_q == nsr_pkg::NSR_ST_EXEC && phase_q == 2'h2
                     && op_q == nsr_pkg::NSR_OP_DISCARD;
    assign stk.push_data = pc_q + `NSR_PC_STEP;

    // ------------------------------------------------------------------------
    // Negate datapath and status flags
    // ------------------------------------------------------------------------
    // Only the negate touches the flags; every other opcode leaves them alone.
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            rd_q <= 8'h00;
            res_q <= 8'h00;
            status_q <= `NSR_STATUS_RST;
        end else if (i_ce) begin
            if (st_q == nsr_pkg::NSR_ST_EXEC && op_q == nsr_pkg::NSR_OP_NEG) begin
                if (phase_q == 2'h1) begin
                    rd_q <= dmem_q[ea_c[DMEM_AW-1:0]];
                end
                if (phase_q == 2'h2) begin
                    res_q <= ~rd_q + 8'h01;
                end
                if (q4) begin
                    status_q[`NSR_ST_C] <= (rd_q == 8'h00);
                    status_q[`NSR_ST_DC] <= (rd_q[3:0] == 4'h0);
                    status_q[`NSR_ST_Z] <= (res_q == 8'h00);
                    status_q[`NSR_ST_OV] <= (rd_q == 8'h80);
                    status_q[`NSR_ST_N] <= res_q[7];
                end
            end else if (bus_wr && i_avs_address == `NSR_OFF_STATUS) begin
                status_q <= wm_c[4:0];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Data memory
    // ------------------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            for (int i = 0; i < DMEM_N; i++) begin
                dmem_q[i] <= 8'h00;
            end
        end else if (i_ce) begin
            if (st_q == nsr_pkg::NSR_ST_EXEC && op_q == nsr_pkg::NSR_OP_NEG && q4) begin
                dmem_q[ea_c[DMEM_AW-1:0]] <= res_q;
            end else if (bus_wr && i_avs_address == `NSR_OFF_DDATA && i_avs_byteenable[0]) begin
                dmem_q[daddr_q[DMEM_AW-1:0]] <= i_avs_writedata[7:0];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    chk_neg_result: assert property (
        i_ce && st_q == nsr_pkg::NSR_ST_EXEC && op_q == nsr_pkg::NSR_OP_NEG && q4
        |=> dmem_q[$past(eaddr_q[DMEM_AW-1:0])] == 8'(8'h00 - $past(rd_q)))
        else $error("negate result is not the two's complement");
    chk_neg_flags: assert property (
        i_ce && st_q == nsr_pkg::NSR_ST_EXEC && op_q == nsr_pkg::NSR_OP_NEG && q4
        |=> status_q[`NSR_ST_Z] == ($past(rd_q) == 8'h00)
            && status_q[`NSR_ST_OV] == ($past(rd_q) == 8'h80) && busy_q == 1'b0)
        else $error("negate flags or length wrong");
    chk_bank_addr: assert property (
        st_q == nsr_pkg::NSR_ST_EXEC && ir_q[8] |-> ea_c == {bank_q, ir_q[7:0]})
        else $error("bank addressing wrong");
    chk_index_addr: assert property (
        st_q == nsr_pkg::NSR_ST_EXEC && !ir_q[8] && ext_q && ir_q[7:0] <= 8'h5f
        |-> ea_c == 12'(index_q + 12'(ir_q[7:0])))
        else $error("indexed literal offset address wrong");
    chk_idle_quiet: assert property (
        i_ce && st_q == nsr_pkg::NSR_ST_EXEC && op_q == nsr_pkg::NSR_OP_IDLE && q4
        |=> $stable(status_q) && $stable(stk.depth) && pc_q == $past(pc_q) + 21'h2
            && st_q == nsr_pkg::NSR_ST_IDLE)
        else $error("idle opcode changed state");
    chk_discard_depth: assert property (
        stk.pop && !stk.empty |=> stk.depth == $past(stk.depth) - PW'(1) && $stable(status_q))
        else $error("discard did not drop the top");
    chk_save_top: assert property (
        stk.push && !stk.full && op_q == nsr_pkg::NSR_OP_SAVE
        |=> stk.top == $past(pc_q) + 21'h2 && stk.depth == $past(stk.depth) + PW'(1))
        else $error("save pushed a wrong address");
    chk_relative_subroutine_call_target: assert property (
        i_ce && st_q == nsr_pkg::NSR_ST_EXEC && op_q == nsr_pkg::NSR_OP_RELATIVE_SUBROUTINE_CALL && q4
        |=> pc_q == 21'($past(pc_q) + 21'h2 + {{9{ir_q[10]}}, ir_q[10:0], 1'b0})
            && $stable(status_q))
        else $error("relative call target wrong");
    chk_relative_subroutine_call_second: assert property (
        i_ce && st_q == nsr_pkg::NSR_ST_EXEC && op_q == nsr_pkg::NSR_OP_RELATIVE_SUBROUTINE_CALL && q4
        |=> st_q == nsr_pkg::NSR_ST_SECOND && busy_q ##1 busy_q [*3] ##1 !busy_q)
        else $error("relative call not two cycles");

endmodule : nsr_core

`default_nettype wire

//--- test_negate_stack_relcall_exec.sv
// Self-checking testbench for the instruction core.
`include "nsr_params.svh"
`timescale 1ns/1ps
`default_nettype none

module test_negate_stack_relcall_exec;
    logic i_mclk = 1'b0;
    logic i_rst = 1'b1;
    logic [5:0] addr = 6'h00;
    logic rd_en = 1'b0;
    logic wr_en = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic wait_req;
    logic busy;
    logic ce = 1'b1;
    logic [63:0] e;
    logic [20:0] pc = 21'h0;
    logic [63:0] rd_q[$];
    int busy_q[$];
    int error_cnt = 0;
    int checked = 0;
    int seed = 16;
    int bcnt = 0;

    always #20 i_mclk = ~i_mclk;

    nsr_core nsr_core_i (.i_mclk(i_mclk), .i_rst(i_rst), .i_ce(ce), .i_avs_address(addr),
        .i_avs_read(rd_en), .i_avs_write(wr_en), .i_avs_writedata(wdata),
        .i_avs_byteenable(4'hf), .o_avs_readdata(rdata), .o_avs_waitrequest(wait_req),
        .o_busy(busy));

    // ------------------------------------------------------------
    // Result checking
    // ------------------------------------------------------------
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp

    task automatic cmp_busy(input int exp, input int got);
        checked++;
        if (got != exp) begin
            error_cnt++;
            $display("CHECK FAILED busy cycles expected %0d seen %0d", exp, got);
        end
    endtask : cmp_busy

    task automatic finish_test();
        if (error_cnt == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : finish_test

    // Compares completed reads and the length of each busy period.
    always @(posedge i_mclk) begin
        if (rd_en && wait_req === 1'b0 && rd_q.size() > 0) begin
            e = rd_q.pop_front();
            cmp("readdata", e[31:0], rdata & e[63:32]);
        end
        if (busy === 1'b1) begin
            bcnt++;
        end else if (bcnt > 0) begin
            if (busy_q.size() > 0) cmp_busy(busy_q.pop_front(), bcnt);
            bcnt = 0;
        end
    end

    // ------------------------------------------------------------
    // Bus and instruction tasks
    // ------------------------------------------------------------
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        int n;
        n = 0;
        rd_en <= !w;
        wr_en <= w;
        addr <= a;
        wdata <= d;
        do begin
            @(posedge i_mclk);
            n++;
        end while (wait_req !== 1'b0 && n < 40);
        if (n >= 40) error_cnt++;
        rd_en <= 1'b0;
        wr_en <= 1'b0;
        @(posedge i_mclk);
    endtask : bus

    task automatic rd(input logic [5:0] a, input logic [31:0] x, input logic [31:0] m = '1);
        rd_q.push_back({m, x & m});
        bus(1'b0, a, 32'h0);
    endtask : rd

    task automatic run(input logic [15:0] op, input int cyc);
        int n;
        n = 0;
        busy_q.push_back(cyc);
        bus(1'b1, `NSR_OFF_INSTR, {16'h0, op});
        while (busy !== 1'b0 && n < 20) begin
            @(posedge i_mclk);
            n++;
        end
        if (n >= 20) error_cnt++;
        if (op[15:11] == `NSR_RELATIVE_SUBROUTINE_CALL_TOP) pc = pc + 21'h2 + {{9{op[10]}}, op[10:0], 1'b0};
        else pc = pc + 21'h2;
    endtask : run

    initial begin
        repeat (20000) @(posedge i_mclk);
        error_cnt++;
        finish_test();
    end

    initial begin
        logic [7:0] v, f, r;
        logic [3:0] bank;
        logic [11:0] idx, ea;
        logic a, ext;
        logic [10:0] n11;
        logic [20:0] ret;
        repeat (2) @(posedge i_mclk);
        i_rst <= 1'b0;
        @(posedge i_mclk);
        rd(`NSR_OFF_STATUS, 32'h0);
        for (int i = 0; i < 8; i++) begin
            v = 8'($random(seed));
            f = 8'($random(seed));
            bank = 4'($random(seed));
            idx = 12'($random(seed));
            a = i[0];
            ext = i[1];
            if (i < 4) f = f % 8'h60;
            if (i == 4) v = 8'h00;
            if (i == 6) v = 8'h80;
            r = 8'h00 - v;
            if (a) ea = {bank, f};
            else if (f > `NSR_ACCESS_LIM) ea = {`NSR_SFR_BANK, f};
            else if (ext) ea = idx + {4'h0, f};
            else ea = {4'h0, f};
            bus(1'b1, `NSR_OFF_BANK, {28'h0, bank});
            bus(1'b1, `NSR_OFF_CFG, {31'h0, ext});
            bus(1'b1, `NSR_OFF_INDEX, {20'h0, idx});
            bus(1'b1, `NSR_OFF_DADDR, {20'h0, ea});
            bus(1'b1, `NSR_OFF_DDATA, {24'h0, v});
            run({`NSR_NEG_TOP, a, f}, 4);
            rd(`NSR_OFF_DDATA, {24'h0, r});
            rd(`NSR_OFF_EADDR, {20'h0, ea});
            rd(`NSR_OFF_STATUS, {27'h0, r[7], v == 8'h80, r == 8'h00, v[3:0] == 4'h0,
                v == 8'h00});
        end
        rd(`NSR_OFF_PC, {11'h0, pc});
        bus(1'b1, `NSR_OFF_STATUS, 32'h15);
        // Freeze the core for a few clocks while the next start request is pending.
        ce <= 1'b0;
        fork
            begin
                repeat (5) @(posedge i_mclk);
                ce <= 1'b1;
            end
        join_none
        run(`NSR_IDLE_WORD, 4);
        run({`NSR_IDLE_TOP, 12'($random(seed))}, 4);
        rd(`NSR_OFF_STATUS, 32'h15);
        rd(`NSR_OFF_PC, {11'h0, pc});
        bus(1'b1, `NSR_OFF_PC, 32'h124);
        pc = 21'h124;
        run(`NSR_SAVE_WORD, 4);
        rd(`NSR_OFF_TOP, 32'h126);
        run(`NSR_SAVE_WORD, 4);
        rd(`NSR_OFF_TOP, 32'h128);
        rd(`NSR_OFF_STATE, 32'h4, 32'h1fe);
        run(`NSR_DISCARD_WORD, 4);
        rd(`NSR_OFF_TOP, 32'h126);
        rd(`NSR_OFF_STATE, 32'h2, 32'h1fe);
        rd(`NSR_OFF_PC, 32'h12a);
        bus(1'b1, `NSR_OFF_PC, 32'h1000);
        pc = 21'h1000;
        for (int k = 0; k < 3; k++) begin
            n11 = (k == 0) ? 11'h400 : (k == 1) ? 11'h3ff : 11'($random(seed));
            ret = pc + 21'h2;
            run({`NSR_RELATIVE_SUBROUTINE_CALL_TOP, n11}, 8);
            rd(`NSR_OFF_TOP, {11'h0, ret});
            rd(`NSR_OFF_PC, {11'h0, pc});
        end
        rd(`NSR_OFF_STATE, 32'h8, 32'h1fe);
        rd(`NSR_OFF_STATUS, 32'h15);
        finish_test();
    end
endmodule : test_negate_stack_relcall_exec

`default_nettype wire
